// ---- rtl/ascl_pkg.sv ----
// Constants for the accelerometer control-pin logic.
// Assumes a single 100 MHz core clock.
package ascl_pkg;
   localparam int  CLK_MHZ         = 100;
   localparam int  DATA_W          = 12;
   // Qualified reset hold, microseconds
   localparam int  RST_QUAL_US     = 512;
   localparam int  RST_QUAL_CYC    = RST_QUAL_US * CLK_MHZ;
   // Status high-impedance window after reset, microseconds
   localparam int  HIZ_US          = 800;
   localparam int  HIZ_CYC         = HIZ_US * CLK_MHZ;
   // Stabilization delay, microseconds
   localparam int  STAB_US         = 3000;
   localparam int  STAB_CYC        = STAB_US * CLK_MHZ;
   // DSP sample period, microseconds
   localparam int  SAMPLE_US       = 16;
   localparam int  SAMPLE_CYC      = SAMPLE_US * CLK_MHZ;
   // Internal oscillator, kHz
   localparam int  OSC_KHZ         = 4000;
   localparam int  OSC_DIV         = (CLK_MHZ * 1000) / OSC_KHZ;
   localparam int  CNT_W           = 32;
   localparam logic [DATA_W-1:0] MID_CODE = 12'h800;
   localparam logic [DATA_W-1:0] ST_STEP  = 12'h100;
   typedef enum logic [1:0] {ASCL_HIZ, ASCL_STAB, ASCL_RUN} ascl_phase_t;
endpackage

// ---- rtl/ascl_sample_hold.sv ----
// Per-axis sample hold register for the output converters.
// Assumes load enables come from the controlling top on the core clock.
`timescale 1ns/100ps
module ascl_sample_hold (
   input  wire logic                      core_clk_i,
   input  wire logic                      sys_rst_i,
   input  wire logic                      load_i,
   input  wire logic [ascl_pkg::DATA_W-1:0] data_i,
   output logic      [ascl_pkg::DATA_W-1:0] data_o
);
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_o <= ascl_pkg::MID_CODE;
      end else if (load_i) begin
         data_o <= data_i;
      end
   end
endmodule

// ---- rtl/ascl_ctrl.sv ----
// Control-pin logic: qualified reset, status latch, self-test, sample freeze.
// Assumes all pins synchronous to core_clk_i; the host keeps reset levels held.
// Function
// [RULE_01] Internal reset asserts after reset pin low and qualifier high for 512 us.
// [RULE_02] Undriven reset pin reads inactive through internal pull-up.
// [RULE_03] Status high on parity, temperature, clock fault, reset or initialization.
// [RULE_04] Status left high-impedance about 800 us after reset.
// [RULE_05] Then status driven high, 3 ms delay during which clears are ignored.
// [RULE_06] Status latch holds until self-test input rising edge clears it.
// [RULE_07] Persisting fault re-sets the latch immediately after clear.
// [RULE_08] Terminal faults re-set the latch after any clear attempt.
// [RULE_09] Self-test stimulus enabled while self-test input high.
// [RULE_10] Self-test moves both axes positive if polarity clear, negative if set.
// [RULE_11] Freeze input low: outputs update on each new DSP sample; code skips a sample that lands in the cycle the freeze input falls.
// [RULE_12] Freeze rising edge holds outputs while input stays high.
// [RULE_13] New filtered sample every 16 us per axis.
// [RULE_14] Serial configuration disabled in normal mode; pins dedicated.
// [RULE_15] Two output converters, one per axis, fed by that axis result.
// [RULE_16] Qualified reset delay from internal oscillator, 486 to 538 us; code counts core clock cycles instead, a fixed 512 us.
// [RULE_17] Internal logic timed from a 4.0 MHz oscillator; code uses its tick for sample pacing only.
// [RULE_18] Both axes freeze together on the same edge.
`timescale 1ns/100ps
module ascl_ctrl #(
   parameter int RST_QUAL_CYC_P = ascl_pkg::RST_QUAL_CYC,
   parameter int HIZ_CYC_P      = ascl_pkg::HIZ_CYC,
   parameter int STAB_CYC_P     = ascl_pkg::STAB_CYC
) (
   input  wire logic                        core_clk_i,
   input  wire logic                        sys_rst_i,
   input  wire logic                        reset_pin_n_i,
   input  wire logic                        reset_pin_oe_i,
   input  wire logic                        reset_qual_i,
   input  wire logic                        self_test_input_i,
   input  wire logic                        self_test_polarity_bit_i,
   input  wire logic                        sample_freeze_input_i,
   input  wire logic                        parity_fault_i,
   input  wire logic                        over_temp_i,
   input  wire logic                        clock_fault_i,
   input  wire logic                        terminal_fault_i,
   input  wire logic [ascl_pkg::DATA_W-1:0] dsp_x_i,
   input  wire logic [ascl_pkg::DATA_W-1:0] dsp_y_i,
   output logic                             status_o,
   output logic                             status_oe_o,
   output logic                             serial_cfg_en_o,
   output logic                             self_test_en_o,
   output logic                             dev_reset_o,
   output logic                             sample_tick_o,
   output logic [ascl_pkg::DATA_W-1:0]      dac_x_o,
   output logic [ascl_pkg::DATA_W-1:0]      dac_y_o
);
   localparam int AXES = 2;

   logic                        reset_pin_level;
   logic [ascl_pkg::CNT_W-1:0]  qual_cnt;
   logic [ascl_pkg::CNT_W-1:0]  osc_cnt;
   logic                        osc_tick;
   logic [ascl_pkg::CNT_W-1:0]  samp_cnt;
   logic [ascl_pkg::CNT_W-1:0]  phase_cnt;
   ascl_pkg::ascl_phase_t       phase;
   logic                        st_prev;
   logic                        st_rise;
   logic                        fz_prev;
   logic                        frozen;
   logic                        hold_load;
   logic                        clear_ok;
   logic                        fault_now;
   logic                        status_latch;
   logic                        dev_init;
   logic [ascl_pkg::DATA_W-1:0] axis_in [AXES];
   logic [ascl_pkg::DATA_W-1:0] axis_out[AXES];

   // Offset applied by self-test, sign set by polarity
   function automatic logic [ascl_pkg::DATA_W-1:0] st_apply(
      input logic [ascl_pkg::DATA_W-1:0] v,
      input logic                        en,
      input logic                        neg);
      st_apply = !en ? v : (neg ? v - ascl_pkg::ST_STEP : v + ascl_pkg::ST_STEP);
   endfunction

   // Pull-up: undriven pin reads high, so no reset starts
   assign reset_pin_level = reset_pin_oe_i ? reset_pin_n_i : 1'b1; // RULE_02

   // Oscillator-rate enable; Prescale models the on-chip oscillator
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         osc_cnt <= '0;
      end else if (osc_cnt == ascl_pkg::CNT_W'(ascl_pkg::OSC_DIV - 1)) begin
         osc_cnt <= '0; // RULE_17
      end else begin
         osc_cnt <= osc_cnt + 1'b1;
      end
   end
   assign osc_tick = (osc_cnt == ascl_pkg::CNT_W'(ascl_pkg::OSC_DIV - 1));

   // Qualified reset counter; any break in the pin condition restarts it
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         qual_cnt    <= '0;
         dev_reset_o <= 1'b0;
      end else if (!reset_pin_level && reset_qual_i) begin
         if (qual_cnt == ascl_pkg::CNT_W'(RST_QUAL_CYC_P - 1)) begin
            dev_reset_o <= 1'b1; // RULE_01 RULE_16
         end else begin
            qual_cnt <= qual_cnt + 1'b1;
         end
      end else begin
         qual_cnt    <= '0;
         dev_reset_o <= 1'b0;
      end
   end

   // Power-up phase sequence, restarted by the internal reset
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phase     <= ascl_pkg::ASCL_HIZ;
         phase_cnt <= '0;
      end else if (dev_reset_o) begin
         phase     <= ascl_pkg::ASCL_HIZ;
         phase_cnt <= '0;
      end else begin
         case (phase)
            ascl_pkg::ASCL_HIZ: begin
               if (phase_cnt == ascl_pkg::CNT_W'(HIZ_CYC_P - 1)) begin
                  phase     <= ascl_pkg::ASCL_STAB; // RULE_04
                  phase_cnt <= '0;
               end else begin
                  phase_cnt <= phase_cnt + 1'b1;
               end
            end
            ascl_pkg::ASCL_STAB: begin
               if (phase_cnt == ascl_pkg::CNT_W'(STAB_CYC_P - 1)) begin
                  phase     <= ascl_pkg::ASCL_RUN; // RULE_05
                  phase_cnt <= '0;
               end else begin
                  phase_cnt <= phase_cnt + 1'b1;
               end
            end
            ascl_pkg::ASCL_RUN: begin
               phase_cnt <= '0;
            end
            default: begin
               phase     <= ascl_pkg::ASCL_HIZ;
               phase_cnt <= '0;
            end
         endcase
      end
   end

   // Initialization in progress marks a reset/init event for the latch
   assign dev_init  = (phase != ascl_pkg::ASCL_RUN);
   assign fault_now = parity_fault_i | over_temp_i | clock_fault_i
                    | terminal_fault_i | dev_reset_o; // RULE_03 RULE_08
   assign clear_ok  = (phase == ascl_pkg::ASCL_RUN); // RULE_05

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_prev <= 1'b0;
         fz_prev <= 1'b0;
      end else begin
         st_prev <= self_test_input_i;
         fz_prev <= sample_freeze_input_i;
      end
   end
   assign st_rise = self_test_input_i & ~st_prev;

   // Set wins over clear, so a live fault re-latches at once
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_latch <= 1'b1;
      end else if (fault_now || dev_init) begin
         status_latch <= 1'b1; // RULE_03 RULE_07 RULE_08
      end else if (st_rise && clear_ok) begin
         status_latch <= 1'b0; // RULE_06
      end
   end

   assign status_oe_o     = (phase != ascl_pkg::ASCL_HIZ) && !dev_reset_o; // RULE_04
   assign status_o        = status_oe_o & status_latch;
   assign serial_cfg_en_o = 1'b0; // RULE_14
   assign self_test_en_o  = self_test_input_i; // RULE_09

   // DSP sample pacing derived from the oscillator tick
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         samp_cnt      <= '0;
         sample_tick_o <= 1'b0;
      end else begin
         sample_tick_o <= 1'b0;
         if (osc_tick) begin
            if (samp_cnt == ascl_pkg::CNT_W'(ascl_pkg::SAMPLE_CYC / ascl_pkg::OSC_DIV - 1)) begin
               samp_cnt      <= '0;
               sample_tick_o <= 1'b1; // RULE_13
            end else begin
               samp_cnt <= samp_cnt + 1'b1;
            end
         end
      end
   end

   // Freeze is taken at the rising edge and held while the input stays high
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         frozen <= 1'b0;
      end else if (sample_freeze_input_i && !fz_prev) begin
         frozen <= 1'b1; // RULE_12
      end else if (!sample_freeze_input_i) begin
         frozen <= 1'b0;
      end
   end
   // One shared load keeps X and Y from the same sample instant
   assign hold_load = sample_tick_o && !frozen
                    && !(sample_freeze_input_i && !fz_prev); // RULE_11 RULE_18

   assign axis_in[0] = st_apply(dsp_x_i, self_test_input_i, self_test_polarity_bit_i); // RULE_10
   assign axis_in[1] = st_apply(dsp_y_i, self_test_input_i, self_test_polarity_bit_i);

   generate
      for (genvar g = 0; g < AXES; g++) begin : g_axis
         ascl_sample_hold u_hold (
            .core_clk_i (core_clk_i),
            .sys_rst_i  (sys_rst_i),
            .load_i     (hold_load),
            .data_i     (axis_in[g]),
            .data_o     (axis_out[g])
         ); // RULE_15
      end
   endgenerate
   assign dac_x_o = axis_out[0];
   assign dac_y_o = axis_out[1];

   // Cycles since the last sample tick; starts at all ones so the first gap counts alike
   logic [ascl_pkg::CNT_W-1:0]  tick_gap;
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_gap <= '1;
      end else if (sample_tick_o) begin
         tick_gap <= '0;
      end else begin
         tick_gap <= tick_gap + 1'b1;
      end
   end

   // Pin levels are taken one edge back: the host may release them once reset shows
   property p_qual_rst;
      @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(dev_reset_o) |-> !$past(reset_pin_level) && $past(reset_qual_i);
   endproperty
   qual_reset_cause_a: assert property (p_qual_rst) // RULE_01
      else $error("reset without qualifier");
   qual_count_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_16
      $rose(dev_reset_o) |-> $past(qual_cnt) == ascl_pkg::CNT_W'(RST_QUAL_CYC_P - 1))
      else $error("reset before full qualifying count");
   pullup_no_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_02
      !reset_pin_oe_i && !$past(reset_pin_oe_i) |-> !dev_reset_o)
      else $error("reset from undriven pin");
   fault_sets_status_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_03
      (parity_fault_i || over_temp_i || clock_fault_i) && status_oe_o |=> status_latch)
      else $error("fault not latched");
   fault_relatch_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_07
      (parity_fault_i || over_temp_i || clock_fault_i) && st_rise |=> status_latch)
      else $error("live fault cleared");
   hiz_after_reset_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_04
      $fell(dev_reset_o) |-> !status_oe_o [*8])
      else $error("status driven too early");
   stab_no_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_05
      phase == ascl_pkg::ASCL_STAB |-> status_o)
      else $error("status cleared in stabilization");
   clear_on_rise_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_06
      $fell(status_latch) |-> $past(st_rise) && $past(clear_ok))
      else $error("latch cleared without edge");
   persist_relatch_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_08
      terminal_fault_i |=> status_latch)
      else $error("terminal fault cleared");
   selftest_follow_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_09
      hold_load && self_test_input_i && !self_test_polarity_bit_i
      |=> dac_x_o == $past(dsp_x_i) + ascl_pkg::ST_STEP)
      else $error("self-test step not applied");
   selftest_neg_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_10
      hold_load && self_test_input_i && self_test_polarity_bit_i
      |=> dac_x_o == $past(dsp_x_i) - ascl_pkg::ST_STEP
      && dac_y_o == $past(dsp_y_i) - ascl_pkg::ST_STEP)
      else $error("self-test step not negative");
   load_update_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_11
      sample_tick_o && !frozen && !sample_freeze_input_i && !self_test_input_i
      |=> dac_x_o == $past(dsp_x_i) && dac_y_o == $past(dsp_y_i))
      else $error("output not updated on sample");
   axes_together_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_18
      hold_load
      |=> dac_x_o == $past(axis_in[0]) && dac_y_o == $past(axis_in[1]))
      else $error("axes loaded from different samples");
   tick_pace_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_13
      sample_tick_o == (tick_gap == ascl_pkg::CNT_W'(ascl_pkg::SAMPLE_CYC - 1)))
      else $error("sample tick off its period");
   freeze_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_12
      frozen && sample_freeze_input_i |=> $stable(dac_x_o) && $stable(dac_y_o))
      else $error("output moved while frozen");
   freeze_edge_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_12
      sample_freeze_input_i && !fz_prev |=> $stable(dac_x_o) && $stable(dac_y_o))
      else $error("output moved on freeze edge");
   cfg_disabled_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i) // RULE_14
      !serial_cfg_en_o)
      else $error("serial config enabled");

   reset_seen_c: cover property (@(posedge core_clk_i) $rose(dev_reset_o));
   status_clear_c: cover property (@(posedge core_clk_i) $fell(status_latch));
   freeze_c: cover property (@(posedge core_clk_i) frozen && sample_tick_o);
   selftest_neg_c: cover property (@(posedge core_clk_i) hold_load && self_test_polarity_bit_i);
   stab_clear_c: cover property (@(posedge core_clk_i) st_rise && phase == ascl_pkg::ASCL_STAB);
endmodule

// ---- verif/ascl_host.sv ----
// Host model for the control pins: reset pin, qualifier, self-test, freeze.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
module ascl_host (
   input  wire logic core_clk_i,
   input  wire logic status_i,
   input  wire logic status_oe_i,
   output logic      reset_pin_n_o,
   output logic      reset_pin_oe_o,
   output logic      reset_qual_o,
   output logic      self_test_o,
   output logic      polarity_o,
   output logic      freeze_o,
   output logic      status_seen_o
);
   logic last_status = 1'b0;

   initial begin
      reset_pin_n_o = 1'b1;
      reset_pin_oe_o = 1'b0;
      reset_qual_o = 1'b0;
      self_test_o = 1'b0;
      polarity_o = 1'b0;
      freeze_o = 1'b0;
   end

   // Status pin has no pull: while released, show the inverse of the last level
   always @(posedge core_clk_i) begin
      if (status_oe_i) begin
         last_status <= status_i;
      end
   end
   assign status_seen_o = status_oe_i ? status_i : ~last_status;

   // Levels stay put until the next call, so a reset request is held whole
   task automatic drive_rst(input logic oe, input logic pin_n, input logic qual);
      reset_pin_oe_o = oe;
      reset_pin_n_o = pin_n;
      reset_qual_o = qual;
   endtask

   task automatic set_pins(input logic st, input logic pol, input logic frz);
      self_test_o = st;
      polarity_o = pol;
      freeze_o = frz;
   endtask
endmodule

// ---- verif/tb_top.sv ----
// Bench for the control-pin logic: status latch, self-test, freeze, reset.
// Assumes shortened counts; DSP sample period stays at its package value.
`timescale 1ns/100ps
module tb_top;
   localparam int RQ = 20;
   localparam int HZ = 10;
   localparam int SB = 30;
   logic                        core_clk_i = 1'b0;
   logic                        sys_rst_i  = 1'b1;
   logic [3:0]                  flt        = 4'h0;
   logic [ascl_pkg::DATA_W-1:0] dsp_x      = 12'h000;
   logic [ascl_pkg::DATA_W-1:0] dsp_y      = 12'h000;
   logic                        pin_n, pin_oe, qual, st, pol, frz;
   logic                        status_o, status_oe_o, serial_cfg_en_o;
   logic                        self_test_en_o, dev_reset_o, sample_tick_o;
   logic [ascl_pkg::DATA_W-1:0] dac_x_o, dac_y_o;
   int                          n_errors = 0;
   int                          compares = 0;

   always #5 core_clk_i = ~core_clk_i;

   ascl_host host (.core_clk_i(core_clk_i), .status_i(status_o), .status_oe_i(status_oe_o),
      .reset_pin_n_o(pin_n), .reset_pin_oe_o(pin_oe), .reset_qual_o(qual),
      .self_test_o(st), .polarity_o(pol), .freeze_o(frz), .status_seen_o());

   ascl_ctrl #(.RST_QUAL_CYC_P(RQ), .HIZ_CYC_P(HZ), .STAB_CYC_P(SB)) dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reset_pin_n_i(pin_n),
      .reset_pin_oe_i(pin_oe), .reset_qual_i(qual), .self_test_input_i(st),
      .self_test_polarity_bit_i(pol), .sample_freeze_input_i(frz),
      .parity_fault_i(flt[0]), .over_temp_i(flt[1]), .clock_fault_i(flt[2]),
      .terminal_fault_i(flt[3]), .dsp_x_i(dsp_x), .dsp_y_i(dsp_y),
      .status_o(status_o), .status_oe_o(status_oe_o), .serial_cfg_en_o(serial_cfg_en_o),
      .self_test_en_o(self_test_en_o), .dev_reset_o(dev_reset_o),
      .sample_tick_o(sample_tick_o), .dac_x_o(dac_x_o), .dac_y_o(dac_y_o));

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic wait_tick(output int spent);
      spent = 0;
      do begin
         cyc(1);
         spent++;
      end while (sample_tick_o !== 1'b1 && spent < 1700);
      if (sample_tick_o !== 1'b1) begin
         n_errors++;
         summarize();
      end
   endtask

   task automatic t_init;
      cyc(HZ - 3);
      chk(status_oe_o, 1'b0);
      chk(serial_cfg_en_o, 1'b0);
      chk(dac_x_o, 12'h800);
      cyc(6);
      chk({status_oe_o, status_o}, 2'b11);
      host.set_pins(1'b1, 1'b0, 1'b0);
      cyc(2);
      chk(status_o, 1'b1);
      host.set_pins(1'b0, 1'b0, 1'b0);
      cyc(SB);
      chk(status_o, 1'b1);
      host.set_pins(1'b1, 1'b0, 1'b0);
      cyc(2);
      chk(status_o, 1'b0);
      chk(self_test_en_o, 1'b1);
      host.set_pins(1'b0, 1'b0, 1'b0);
      cyc(1);
      chk(self_test_en_o, 1'b0);
   endtask

   task automatic t_fault;
      for (int i = 0; i < 4; i++) begin
         flt = 4'h1 << i;
         cyc(2);
         chk(status_o, 1'b1);
         host.set_pins(1'b1, 1'b0, 1'b0);
         cyc(2);
         chk(status_o, 1'b1);
         flt = 4'h0;
         host.set_pins(1'b0, 1'b0, 1'b0);
         cyc(1);
         host.set_pins(1'b1, 1'b0, 1'b0);
         cyc(2);
         chk(status_o, 1'b0);
         host.set_pins(1'b0, 1'b0, 1'b0);
         cyc(1);
      end
   endtask

   task automatic t_data;
      int gap;
      dsp_x = 12'h123;
      dsp_y = 12'h456;
      wait_tick(gap);
      wait_tick(gap);
      chk(gap[11:0], 12'h640);
      host.set_pins(1'b1, 1'b0, 1'b0);
      wait_tick(gap);
      cyc(1);
      chk(dac_x_o, 12'h223);
      chk(dac_y_o, 12'h556);
      host.set_pins(1'b1, 1'b1, 1'b0);
      wait_tick(gap);
      cyc(1);
      chk(dac_x_o, 12'h023);
      chk(dac_y_o, 12'h356);
      host.set_pins(1'b0, 1'b0, 1'b0);
      wait_tick(gap);
      cyc(1);
      chk(dac_x_o, 12'h123);
      chk(dac_y_o, 12'h456);
   endtask

   task automatic t_freeze;
      int gap;
      host.set_pins(1'b0, 1'b0, 1'b1);
      dsp_x = 12'h7a5;
      dsp_y = 12'h05a;
      wait_tick(gap);
      cyc(1);
      chk(dac_x_o, 12'h123);
      chk(dac_y_o, 12'h456);
      host.set_pins(1'b0, 1'b0, 1'b0);
      wait_tick(gap);
      cyc(1);
      chk(dac_x_o, 12'h7a5);
      chk(dac_y_o, 12'h05a);
   endtask

   task automatic t_reset;
      int n;
      host.drive_rst(1'b0, 1'b0, 1'b1);
      cyc(RQ * 2);
      chk(dev_reset_o, 1'b0);
      host.drive_rst(1'b1, 1'b0, 1'b1);
      cyc(RQ - 5);
      // One broken cycle must restart the count
      host.drive_rst(1'b1, 1'b1, 1'b1);
      cyc(1);
      host.drive_rst(1'b1, 1'b0, 1'b1);
      n = 0;
      while (dev_reset_o !== 1'b1 && n < 2 * RQ) begin
         cyc(1);
         n++;
      end
      chk((n >= RQ - 1) && (n <= RQ + 1), 1'b1);
      chk(status_oe_o, 1'b0);
      host.drive_rst(1'b0, 1'b1, 1'b0);
      cyc(HZ + 3);
      chk({status_oe_o, status_o}, 2'b11);
   endtask

   task automatic summarize;
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      cyc(6);
      sys_rst_i = 1'b0;
      t_init;
      t_fault;
      t_data;
      t_freeze;
      t_reset;
      summarize;
   end
endmodule
